// >>> core/crps_pkg.sv
// Function
// R1: rate bit ignored while double speed off
// R2: double speed: bit 0 gives 6, 1 gives 12
// R3: rate register resets rate bit to zero
// R4: two 16-bit pointers, select bit 0
// R5: select 0 first pointer, 1 second
// R6: boot enable maps boot ROM at F800h-FFFFh
// R7: bit 2 reads zero, ignores writes
// R8: pointer select and bit 2 reset zero
// R9: software never sets reserved auxiliary bits
// R10: double speed off: 12 periods, on: 6
// R11: pointer operations touch only selected pointer
package crps_pkg;

    // ****************************************************
    // register indices; byte address is four times index
    // ****************************************************
    localparam logic [7:0]  CRPS_IDX_PTR_BOOT  = 8'hA2;
    localparam logic [7:0]  CRPS_IDX_RATE      = 8'hAF;
    localparam logic [7:0]  CRPS_IDX_CORE_CTRL = 8'hC0;
    localparam logic [7:0]  CRPS_IDX_PTR_FIRST = 8'hC1;
    localparam logic [7:0]  CRPS_IDX_PTR_SECND = 8'hC2;
    localparam logic [7:0]  CRPS_IDX_PTR_ACT   = 8'hC3;
    localparam int          CRPS_ADDR_LSB      = 2;
    localparam int          CRPS_IDX_W         = 10;

    // ****************************************************
    // field positions and reset values
    // ****************************************************
    localparam int          CRPS_BIT_SEL       = 0;
    localparam int          CRPS_BIT_ZERO      = 2;
    localparam int          CRPS_BIT_FLAG      = 3;
    localparam int          CRPS_BIT_BOOT      = 5;
    localparam int          CRPS_BIT_RATE      = 0;
    localparam int          CRPS_BIT_DSPEED    = 0;
    localparam logic [7:0]  CRPS_PTR_BOOT_MASK = 8'h29;
    localparam logic [7:0]  CRPS_RST_PTR_BOOT  = 8'h00;
    localparam logic        CRPS_RST_RATE      = 1'b0;
    localparam logic        CRPS_RST_DSPEED    = 1'b0;
    localparam logic [15:0] CRPS_RST_PTR       = 16'h0000;

    // ****************************************************
    // boot window and timing in oscillator periods
    // ****************************************************
    localparam logic [15:0] CRPS_BOOT_LO       = 16'hF800;
    localparam logic [15:0] CRPS_BOOT_HI       = 16'hFFFF;
    localparam int          CRPS_PER_STD       = 12;
    localparam int          CRPS_PER_FAST      = 6;

    typedef enum logic {CRPS_BUS_IDLE, CRPS_BUS_RDWAIT} crps_bus_t;

endpackage

// >>> core/crps_rate_div.sv
`timescale 1ns/1ps
`default_nettype none
// one clk_sys cycle stands for one oscillator period
module crps_rate_div
    import crps_pkg::*;
#(
    parameter int SLOW = CRPS_PER_STD,
    parameter int FAST = CRPS_PER_FAST
) (
    input  wire logic clk_sys,   // core clock
    input  wire logic rst_n,     // async reset, low
    input  wire logic fast,      // pick FAST period
    output logic      tick       // one-cycle enable
);
    localparam logic [3:0] LAST_SLOW = 4'(SLOW - 1);
    localparam logic [3:0] LAST_FAST = 4'(FAST - 1);

    logic [3:0] count;
    wire  [3:0] last = fast ? LAST_FAST : LAST_SLOW;
    // a switch to a shorter period may leave count above last
    wire        wrap = (count >= last);
    wire  [3:0] next_count = wrap ? 4'h0 : 4'(count + 4'h1);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count <= 4'h0;
            tick  <= 1'b0;
        end else begin
            count <= next_count;
            tick  <= wrap;
        end
    end
endmodule // crps_rate_div
`default_nettype wire

// >>> core/crps_pointer.sv
`timescale 1ns/1ps
`default_nettype none
module crps_pointer
    import crps_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic         clk_sys,  // core clock
    input  wire logic         rst_n,    // async reset, low
    input  wire logic         load,     // load this pointer
    input  wire logic [W-1:0] load_val, // value to load
    input  wire logic         inc,      // increment this pointer
    output logic      [W-1:0] value     // pointer contents
);
    wire [W-1:0] next_value = load ? load_val :
                              inc  ? W'(value + 1'b1) : value;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            value <= W'(CRPS_RST_PTR);
        end else begin
            value <= next_value;
        end
    end
endmodule // crps_pointer
`default_nettype wire

// >>> core/crps_top.sv
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none
module crps_top
    import crps_pkg::*;
#(
    parameter int PTR_W = 16
) (
    input  wire logic             clk_sys,      // core clock
    input  wire logic             rst_n,        // async reset, low
    input  wire logic             hsel,         // slave select
    input  wire logic [31:0]      haddr,        // byte address
    input  wire logic [1:0]       htrans,       // transfer type
    input  wire logic             hwrite,       // write access
    input  wire logic [2:0]       hsize,        // word only
    input  wire logic [31:0]      hwdata,       // write data
    input  wire logic             hready,       // bus ready in
    output logic      [31:0]      hrdata,       // read data
    output logic                  hreadyout,    // slave ready
    output logic                  hresp,        // always okay
    input  wire logic             dp_load,      // cpu pointer load
    input  wire logic [PTR_W-1:0] dp_load_val,  // cpu load value
    input  wire logic             dp_inc,       // cpu pointer incr
    input  wire logic [15:0]      code_addr,    // code fetch address
    output logic      [PTR_W-1:0] data_pointer, // selected pointer
    output logic                  boot_rom_sel, // fetch hits boot ROM
    output logic                  boot_rom_map_enable, // map enable
    output logic                  machine_tick, // machine cycle pulse
    output logic                  spi_tick      // spi periph pulse
);

    // ****************************************************
    // bus address phase
    // ****************************************************
    logic                  wr_pend;
    logic [CRPS_IDX_W-1:0] wr_idx;
    logic [CRPS_IDX_W-1:0] rd_idx;
    crps_bus_t             bus_state;

    wire                  take    = hsel & htrans[1] & hready;
    wire                  take_wr = take & hwrite;
    wire                  take_rd = take & ~hwrite;
    wire [CRPS_IDX_W-1:0] a_idx   =
        haddr[CRPS_IDX_W+CRPS_ADDR_LSB-1:CRPS_ADDR_LSB];

    // ****************************************************
    // write decode, data phase
    // ****************************************************
    wire wr_ptr_boot = wr_pend & (wr_idx == CRPS_IDX_W'(CRPS_IDX_PTR_BOOT));
    wire wr_rate     = wr_pend & (wr_idx == CRPS_IDX_W'(CRPS_IDX_RATE));
    wire wr_core     = wr_pend & (wr_idx == CRPS_IDX_W'(CRPS_IDX_CORE_CTRL));
    wire wr_first    = wr_pend & (wr_idx == CRPS_IDX_W'(CRPS_IDX_PTR_FIRST));
    wire wr_secnd    = wr_pend & (wr_idx == CRPS_IDX_W'(CRPS_IDX_PTR_SECND));
    wire wr_act      = wr_pend & (wr_idx == CRPS_IDX_W'(CRPS_IDX_PTR_ACT));

    // ****************************************************
    // control registers
    // ****************************************************
    logic [7:0] ptr_boot;
    logic       serial_periph_rate_select;
    logic       core_double_speed;

    // reserved bits and bit 2 never store, so they read zero
    wire [7:0] next_ptr_boot = hwdata[7:0] & CRPS_PTR_BOOT_MASK; // see R7 R9

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ptr_boot <= CRPS_RST_PTR_BOOT; // see R8
        end else if (wr_ptr_boot) begin
            ptr_boot <= next_ptr_boot;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            serial_periph_rate_select <= CRPS_RST_RATE; // see R3
        end else if (wr_rate) begin
            serial_periph_rate_select <= hwdata[CRPS_BIT_RATE];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            core_double_speed <= CRPS_RST_DSPEED;
        end else if (wr_core) begin
            core_double_speed <= hwdata[CRPS_BIT_DSPEED];
        end
    end

    wire pointer_select   = ptr_boot[CRPS_BIT_SEL];
    wire user_flag_three  = ptr_boot[CRPS_BIT_FLAG];
    wire next_boot_enable = ptr_boot[CRPS_BIT_BOOT];

    // ****************************************************
    // dual data pointers
    // ****************************************************
    // cpu load beats a register write in the same cycle
    wire             any_load = dp_load | wr_act;
    wire [PTR_W-1:0] load_val = dp_load ? dp_load_val : PTR_W'(hwdata);
    wire             load_first = (any_load & ~pointer_select) | wr_first; // see R11
    wire             load_secnd = (any_load & pointer_select) | wr_secnd; // see R11
    wire [PTR_W-1:0] first_val  = (any_load & ~pointer_select) ?
                                  load_val : PTR_W'(hwdata);
    wire [PTR_W-1:0] secnd_val  = (any_load & pointer_select) ?
                                  load_val : PTR_W'(hwdata);
    wire             inc_first  = dp_inc & ~pointer_select; // see R11
    wire             inc_secnd  = dp_inc & pointer_select;  // see R11

    logic [PTR_W-1:0] first_data_pointer;
    logic [PTR_W-1:0] second_data_pointer;

    crps_pointer #(.W(PTR_W)) u_first (                 // see R4
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .load     (load_first),
        .load_val (first_val),
        .inc      (inc_first),
        .value    (first_data_pointer)
    );

    crps_pointer #(.W(PTR_W)) u_secnd (                 // see R4
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .load     (load_secnd),
        .load_val (secnd_val),
        .inc      (inc_secnd),
        .value    (second_data_pointer)
    );

    // output lags a select change or pointer update by one cycle
    wire [PTR_W-1:0] next_data_pointer = pointer_select ?
        second_data_pointer : first_data_pointer; // see R5

    // ****************************************************
    // boot ROM window
    // ****************************************************
    wire next_boot_rom_sel = next_boot_enable &
        (code_addr >= CRPS_BOOT_LO) & (code_addr <= CRPS_BOOT_HI); // see R6

    // ****************************************************
    // rate dividers
    // ****************************************************
    // rate bit only consulted once double speed is on
    wire spi_fast = core_double_speed & ~serial_periph_rate_select; // see R1 R2
    logic mc_tick_raw;
    logic spi_tick_raw;

    crps_rate_div u_machine (                           // see R10
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .fast    (core_double_speed),
        .tick    (mc_tick_raw)
    );

    crps_rate_div u_spi (                               // see R2
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .fast    (spi_fast),
        .tick    (spi_tick_raw)
    );

    // ****************************************************
    // read mux
    // ****************************************************
    wire [31:0] rd_ptr_boot = {24'h000000, ptr_boot};
    wire [31:0] rd_rate     = {31'h00000000, serial_periph_rate_select};
    wire [31:0] rd_core     = {31'h00000000, core_double_speed};
    wire [31:0] rd_first    = 32'(first_data_pointer);
    wire [31:0] rd_secnd    = 32'(second_data_pointer);
    wire [31:0] rd_act      = 32'(next_data_pointer);

    // unmapped addresses read zero
    wire [31:0] next_hrdata =
        (rd_idx == CRPS_IDX_W'(CRPS_IDX_PTR_BOOT))  ? rd_ptr_boot :
        (rd_idx == CRPS_IDX_W'(CRPS_IDX_RATE))      ? rd_rate     :
        (rd_idx == CRPS_IDX_W'(CRPS_IDX_CORE_CTRL)) ? rd_core     :
        (rd_idx == CRPS_IDX_W'(CRPS_IDX_PTR_FIRST)) ? rd_first    :
        (rd_idx == CRPS_IDX_W'(CRPS_IDX_PTR_SECND)) ? rd_secnd    :
        (rd_idx == CRPS_IDX_W'(CRPS_IDX_PTR_ACT))   ? rd_act      :
        32'h00000000;

    // ****************************************************
    // bus sequencing
    // ****************************************************
    // one wait state on reads so a read right after a write
    // sees the freshly written value
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bus_state <= CRPS_BUS_IDLE;
            hreadyout <= 1'b1;
            rd_idx    <= '0;
        end else begin
            unique case (bus_state)
                CRPS_BUS_IDLE: begin
                    if (take_rd) begin
                        bus_state <= CRPS_BUS_RDWAIT;
                        hreadyout <= 1'b0;
                        rd_idx    <= a_idx;
                    end
                end
                CRPS_BUS_RDWAIT: begin
                    bus_state <= CRPS_BUS_IDLE;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend <= 1'b0;
            wr_idx  <= '0;
        end else begin
            wr_pend <= take_wr;
            wr_idx  <= a_idx;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h00000000;
            hresp  <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (bus_state == CRPS_BUS_RDWAIT) begin
                hrdata <= next_hrdata;
            end
        end
    end

    // ****************************************************
    // registered outputs
    // ****************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            data_pointer        <= PTR_W'(CRPS_RST_PTR);
            boot_rom_sel        <= 1'b0;
            boot_rom_map_enable <= 1'b0;
            machine_tick        <= 1'b0;
            spi_tick            <= 1'b0;
        end else begin
            data_pointer        <= next_data_pointer;
            boot_rom_sel        <= next_boot_rom_sel;
            boot_rom_map_enable <= next_boot_enable; // see R6
            machine_tick        <= mc_tick_raw;
            spi_tick            <= spi_tick_raw;
        end
    end

endmodule // crps_top
`default_nettype wire

// >>> tb/crps_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module crps_monitor
    import crps_pkg::*;
#(
    parameter int PTR_W = 16
) (
    input wire logic             clk_sys,      // core clock
    input wire logic             rst_n,        // async reset
    input wire logic             hsel,         // slave select
    input wire logic [1:0]       htrans,       // transfer type
    input wire logic             hwrite,       // write access
    input wire logic             hready,       // bus ready
    input wire logic             hreadyout,    // slave ready
    input wire logic             hresp,        // response
    input wire logic             dp_load,      // pointer load
    input wire logic [PTR_W-1:0] dp_load_val,  // load value
    input wire logic             dp_inc,       // pointer incr
    input wire logic [15:0]      code_addr,    // fetch address
    input wire logic [PTR_W-1:0] data_pointer, // selected pointer
    input wire logic             boot_rom_sel, // boot hit
    input wire logic             boot_rom_map_enable, // map enable
    input wire logic             machine_tick, // machine pulse
    input wire logic             spi_tick      // spi pulse
);
    // ********
    // helpers
    // ********
    wire logic rd_take = hsel && htrans[1] && hready && !hwrite;
    wire logic wr_take = hsel && htrans[1] && hready && hwrite;
    logic      wr_dph;
    // a write landing at the same edge may retarget the pointer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_dph <= 1'b0;
        end else begin
            wr_dph <= wr_take;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ********
    // checks
    // ********
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("hresp not okay");
    chk_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    chk_write_fast: assert property (wr_take |=> hreadyout)
        else $error("write stalled");
    chk_ready_cause: assert property ($fell(hreadyout) |-> $past(rd_take))
        else $error("stall without read");
    chk_boot_window: assert property (
        boot_rom_sel == (boot_rom_map_enable && $past(code_addr) >= CRPS_BOOT_LO))
        else $error("boot select wrong");
    chk_mtick_min: assert property (
        machine_tick |=> !machine_tick [*5])
        else $error("machine tick too soon");
    chk_mtick_max: assert property (
        machine_tick |-> ##[1:12] machine_tick)
        else $error("machine tick too late");
    chk_stick_min: assert property (spi_tick |=> !spi_tick [*5])
        else $error("spi tick too soon");
    chk_stick_max: assert property (spi_tick |-> ##[1:12] spi_tick)
        else $error("spi tick too late");
    chk_ptr_inc: assert property (
        dp_inc && !dp_load && !wr_dph |-> ##2
        data_pointer == $past(data_pointer) + 1'b1)
        else $error("pointer increment wrong");
    chk_ptr_load: assert property (
        dp_load && !wr_dph |-> ##2 data_pointer == $past(dp_load_val, 2))
        else $error("pointer load wrong");
    cover property (rd_take);
    cover property (boot_rom_sel);
    cover property (dp_inc ##2 machine_tick);
endmodule // crps_monitor

bind crps_top crps_monitor #(.PTR_W(PTR_W)) u_mon (.clk_sys, .rst_n,
    .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .dp_load,
    .dp_load_val, .dp_inc, .code_addr, .data_pointer, .boot_rom_sel,
    .boot_rom_map_enable, .machine_tick, .spi_tick);
`default_nettype wire

// >>> tb/crps_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module crps_top_test
    import crps_pkg::*;
;
    logic        clk_sys = 1'h0, rst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic        dp_load = 1'h0, dp_inc = 1'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdat, e;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [15:0] dp_load_val = 16'h0, code_addr = 16'h0, data_pointer;
    logic [15:0] ca [3] = '{16'hF7FF, 16'hF800, 16'hFFFF};
    logic        hreadyout, hresp, boot_rom_sel, boot_rom_map_enable;
    logic        machine_tick, spi_tick;
    wire logic   hready = hreadyout;
    int          n_errors = 0, check_count = 0, k, g;

    always #2 clk_sys = ~clk_sys;

    crps_top #(.PTR_W(16)) DUT (.clk_sys, .rst_n, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
        .dp_load, .dp_load_val, .dp_inc, .code_addr, .data_pointer,
        .boot_rom_sel, .boot_rom_map_enable, .machine_tick, .spi_tick);

    // ********
    // tasks
    // ********
    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] x,
                       input logic [31:0] got);
        check_count++;
        if (got !== x) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, x, got);
        end
    endtask

    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        if (n >= 40) begin
            n_errors++;
            print_verdict;
        end
    endtask

    // address phase held until ready, then data phase until ready
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready;
        rdat = hrdata;
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] x,
                      input string what);
        bus(1'b0, idx, 32'h0);
        chk(what, x, rdat);
    endtask

    task automatic cpu(input logic ld, input logic [15:0] v,
                       input logic inc);
        dp_load <= ld;
        dp_load_val <= v;
        dp_inc <= inc;
        @(posedge clk_sys);
        dp_load <= 1'b0;
        dp_inc <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask

    // gap between the second and third pulse seen
    task automatic gap(input logic spi, output int gp);
        int n, j;
        for (j = 0; j < 3; j++) begin
            n = 0;
            do begin
                @(posedge clk_sys);
                n++;
            end while ((spi ? spi_tick : machine_tick) !== 1'b1 && n < 40);
            if (n >= 40) begin
                n_errors++;
                print_verdict;
            end
            gp = n;
        end
    endtask

    // ********
    // sequence
    // ********
    initial begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rd(CRPS_IDX_PTR_BOOT, 32'h0, "aux reset");
        rd(CRPS_IDX_RATE, 32'h0, "rate reset");
        bus(1'b1, 8'h00, 32'hFFFFFFFF);
        rd(8'h00, 32'h0, "unmapped");
        chk("pointer reset", 32'h0, data_pointer);
        $display("test reset done");
        bus(1'b1, CRPS_IDX_PTR_BOOT, 32'h0D);
        rd(CRPS_IDX_PTR_BOOT, 32'h09, "aux write");
        for (k = 0; k < 2; k++) begin
            bus(1'b0, CRPS_IDX_PTR_BOOT, 32'h0);
            e = rdat;
            bus(1'b1, CRPS_IDX_PTR_BOOT, e + 32'h1);
            rd(CRPS_IDX_PTR_BOOT, e ^ 32'h1, "aux increment");
        end
        $display("test aux done");
        bus(1'b1, CRPS_IDX_PTR_BOOT, 32'h0);
        bus(1'b1, CRPS_IDX_PTR_FIRST, 32'h1234);
        bus(1'b1, CRPS_IDX_PTR_SECND, 32'hBEEF);
        cpu(1'b0, 16'h0, 1'b1);
        chk("first pointer", 32'h1235, data_pointer);
        rd(CRPS_IDX_PTR_SECND, 32'hBEEF, "second kept");
        bus(1'b1, CRPS_IDX_PTR_BOOT, 32'h1);
        repeat (2) @(posedge clk_sys);
        chk("second pointer", 32'hBEEF, data_pointer);
        cpu(1'b1, 16'hFFFF, 1'b0);
        cpu(1'b0, 16'h0, 1'b1);
        chk("pointer wrap", 32'h0, data_pointer);
        bus(1'b1, CRPS_IDX_PTR_ACT, 32'h5A5A);
        rd(CRPS_IDX_PTR_SECND, 32'h5A5A, "active write");
        rd(CRPS_IDX_PTR_FIRST, 32'h1235, "first kept");
        rd(CRPS_IDX_PTR_ACT, 32'h5A5A, "active pointer");
        $display("test pointer done");
        for (k = 0; k < 6; k++) begin
            bus(1'b1, CRPS_IDX_PTR_BOOT, (k / 3) ? 32'h20 : 32'h0);
            code_addr <= ca[k % 3];
            repeat (3) @(posedge clk_sys);
            chk("boot enable", k / 3, boot_rom_map_enable);
            chk("boot select", (k / 3) && ca[k % 3] >= CRPS_BOOT_LO,
                boot_rom_sel);
        end
        $display("test boot done");
        for (k = 0; k < 4; k++) begin
            bus(1'b1, CRPS_IDX_CORE_CTRL, k / 2);
            bus(1'b1, CRPS_IDX_RATE, k % 2);
            gap(1'b0, g);
            chk("machine gap", (k / 2) ? 6 : 12, g);
            gap(1'b1, g);
            chk("spi gap", (k == 2) ? 6 : 12, g);
        end
        $display("test rate done");
        print_verdict;
    end
endmodule // crps_top_test
`default_nettype wire
